// File: hw/debug_serial_uart.sv
// Purpose: debug serial port with Avalon-MM register access
// Assumes: serial_rx synchronous to clock; one clock
// Notes: one wait state per access
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "debug_uart_defs.svh"
module debug_serial_uart (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic serial_rx,
    output logic serial_tx,
    output logic tx_irq,
    output logic rx_irq
);
    // ----------------------------------------
    // state and helpers
    // ----------------------------------------
    debug_uart_pkg::core_state_t s_q;
    debug_uart_pkg::core_state_t s_d;
    logic sel_st;
    logic sel_lo;
    logic sel_hi;
    logic sel_div;
    logic first;
    logic taken;
    logic wr_data;
    logic rd_data;
    logic busy;
    logic rx_commit;
    logic [7:0] wr_byte;
    logic [8:0] cnt_inc;

    serial_link_if link ();

    baud_prescaler u_prescaler (
        .clock(clock),
        .sys_rst(sys_rst),
        .link(link.gen)
    );

    tx_shifter u_tx (
        .clock(clock),
        .sys_rst(sys_rst),
        .link(link.tx)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    assign sel_st = address == {`IDX_SERIAL_STATUS, 2'b00};
    assign sel_lo = address == {`IDX_SERIAL_BYTE_LOW, 2'b00};
    assign sel_hi = address == {`IDX_SERIAL_BYTE_HIGH, 2'b00};
    assign sel_div = address == {`IDX_BAUD_DIVIDER, 2'b00};
    assign first = (read || write) && s_q.waitreq;
    assign taken = (read || write) && !s_q.waitreq;
    assign wr_data = taken && write && ((sel_lo && byteenable[0]) || (sel_hi && byteenable[1]));
    assign rd_data = taken && read && (sel_lo || sel_hi);
    assign wr_byte = sel_hi ? writedata[15:8] : writedata[7:0];
    assign busy = link.shifting || s_q.load;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        rx_commit = 1'b0;
        cnt_inc = {1'b0, s_q.rx_cnt} + 9'h001;
        s_d.load = 1'b0;
        s_d.tx_irq = 1'b0;
        s_d.rx_irq = 1'b0;
        s_d.rx_prev = serial_rx;

        // receiver, paced by the first divider stage
        unique case (s_q.rx_state)
            debug_uart_pkg::RX_IDLE: begin
                if (s_q.rx_prev && !serial_rx) begin
                    s_d.rx_state = debug_uart_pkg::RX_START;
                    s_d.rx_cnt = 8'h00;
                end
            end
            debug_uart_pkg::RX_START: begin
                if (link.sample_tick) begin
                    // half a bit lands the later samples mid bit
                    if (cnt_inc >= {2'b00, s_q.div[7:1]}) begin
                        s_d.rx_cnt = 8'h00;
                        s_d.rx_bits = 3'h0;
                        // a glitch shorter than half a bit is dropped
                        s_d.rx_state = serial_rx ? debug_uart_pkg::RX_IDLE
                                                 : debug_uart_pkg::RX_DATA;
                    end else begin
                        s_d.rx_cnt = cnt_inc[7:0];
                    end
                end
            end
            debug_uart_pkg::RX_DATA: begin
                if (link.sample_tick) begin
                    if (cnt_inc >= {1'b0, s_q.div[7:0]}) begin
                        s_d.rx_cnt = 8'h00;
                        s_d.rx_shift = {serial_rx, s_q.rx_shift[7:1]};
                        s_d.rx_bits = s_q.rx_bits + 3'h1;
                        if (s_q.rx_bits == `DATA_LAST) begin
                            s_d.rx_state = debug_uart_pkg::RX_STOP;
                        end
                    end else begin
                        s_d.rx_cnt = cnt_inc[7:0];
                    end
                end
            end
            debug_uart_pkg::RX_STOP: begin
                if (link.sample_tick) begin
                    if (cnt_inc >= {1'b0, s_q.div[7:0]}) begin
                        s_d.rx_cnt = 8'h00;
                        rx_commit = serial_rx;
                        s_d.rx_state = debug_uart_pkg::RX_IDLE;
                    end else begin
                        s_d.rx_cnt = cnt_inc[7:0];
                    end
                end
            end
        endcase

        // bus: read data captured in the first cycle, answered in the second
        s_d.waitreq = !first;
        if (first) begin
            s_d.rd_fresh = !rx_commit;
            s_d.rdata = 32'h0000_0000;
            if (sel_st) begin
                s_d.rdata[`ST_RX_OVERRUN] = s_q.overrun;
                s_d.rdata[`ST_RX_FULL] = s_q.rx_full;
                s_d.rdata[`ST_TX_FULL] = s_q.tx_full;
                s_d.rdata[`ST_TX_SHIFTING] = link.shifting;
            end else if (sel_lo) begin
                s_d.rdata[7:0] = s_q.rx_byte;
            end else if (sel_hi) begin
                s_d.rdata[15:8] = s_q.rx_byte;
            end else if (sel_div) begin
                s_d.rdata[15:0] = s_q.div;
            end
        end
        if (taken && write && sel_div) begin
            if (byteenable[1]) begin
                s_d.div[15:8] = writedata[15:8];
            end
            if (byteenable[0]) begin
                s_d.div[7:0] = writedata[7:0];
            end
        end
        // a byte landing while the read was waiting is not cleared unseen
        if (rd_data && s_q.rd_fresh) begin
            s_d.rx_full = 1'b0;
        end
        if (rx_commit) begin
            s_d.rx_byte = s_q.rx_shift;
            s_d.overrun = s_q.rx_full;
            s_d.rx_full = 1'b1;
            s_d.rx_irq = 1'b1;
        end

        // transmit holding register
        if (wr_data) begin
            s_d.tx_byte = wr_byte;
            if (!busy && !s_q.tx_full) begin
                s_d.load = 1'b1;
                s_d.tx_irq = 1'b1;
            end else begin
                // a write while full replaces the held byte
                s_d.tx_full = 1'b1;
            end
        end else if (s_q.tx_full && !busy) begin
            s_d.load = 1'b1;
            s_d.tx_full = 1'b0;
            s_d.tx_irq = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.div <= `DIV_RESET;
            s_q.waitreq <= 1'b1;
            s_q.rx_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.prescale = s_q.div[15:8];
    assign link.bit_div = s_q.div[7:0];
    assign link.load = s_q.load;
    assign link.load_byte = s_q.tx_byte;
    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitreq;
    assign serial_tx = link.line;
    assign tx_irq = s_q.tx_irq;
    assign rx_irq = s_q.rx_irq;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    line_idle_high_a: assert property (!link.shifting |-> link.line)
        else $error("transmit line low while idle");

    start_bit_low_a: assert property ($rose(link.shifting) |-> !link.line)
        else $error("frame does not open with a low start bit");

    overrun_copy_a: assert property (
        rx_commit |=> s_q.overrun == $past(s_q.rx_full))
        else $error("overrun not copied from previous full state");

    rx_store_a: assert property (
        rx_commit |=> s_q.rx_full && s_q.rx_state == debug_uart_pkg::RX_IDLE
            && s_q.rx_byte == $past(s_q.rx_shift))
        else $error("received byte not stored");

    read_clear_a: assert property (
        rd_data && s_q.rd_fresh && !rx_commit |=> !s_q.rx_full)
        else $error("data read did not clear receive full");

    low_read_zero_a: assert property (
        first && read && sel_lo |=> readdata[31:8] == 24'h000000 && !waitrequest)
        else $error("low data read has nonzero upper bits");

    tx_start_idle_a: assert property (
        wr_data && !busy && !s_q.tx_full |=> tx_irq ##1 (link.shifting && !link.line))
        else $error("idle write did not start a frame");

    tx_full_hold_a: assert property (wr_data && busy |=> s_q.tx_full)
        else $error("busy write did not set transmit full");

    load_empties_a: assert property (s_q.load |-> !s_q.tx_full && !link.shifting)
        else $error("load while holding register still full");

    irq_pulse_a: assert property ((tx_irq |=> !tx_irq) and (rx_irq |=> !rx_irq))
        else $error("interrupt request longer than one cycle");

    rx_irq_cause_a: assert property (rx_irq |-> $past(rx_commit))
        else $error("receive interrupt without byte transfer");

    bad_stop_a: assert property (
        s_q.rx_state == debug_uart_pkg::RX_STOP && s_d.rx_state == debug_uart_pkg::RX_IDLE
            && !serial_rx |=> !rx_irq && $stable(s_q.rx_byte))
        else $error("frame with low stop bit was kept");

    bus_answer_a: assert property ((read || write) |-> ##[0:1] !waitrequest)
        else $error("bus request not answered within one wait state");

    rx_overrun_c: cover property (rx_commit && s_q.rx_full);
    tx_pending_c: cover property (s_q.tx_full && !busy ##1 s_q.load);
    status_read_c: cover property (taken && read && sel_st);
endmodule : debug_serial_uart

// File: pkg/debug_uart_defs.svh
// Purpose: offsets, field positions, reset values and counts of the debug serial port
// Assumes: register offsets are word indices; byte address is four times the index
// Notes: definitions only
`ifndef DEBUG_UART_DEFS_SVH
`define DEBUG_UART_DEFS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_SERIAL_STATUS 16'hC028
`define IDX_SERIAL_BYTE_LOW 16'hC029
`define IDX_SERIAL_BYTE_HIGH 16'hC02A
`define IDX_BAUD_DIVIDER 16'hC02B

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ST_RX_OVERRUN 3
`define ST_RX_FULL 2
`define ST_TX_FULL 1
`define ST_TX_SHIFTING 0
`define DIV_RESET 16'h0000
`define FRAME_LAST 4'h9
`define DATA_LAST 3'h7

`endif

// File: pkg/debug_uart_pkg.sv
// Purpose: state types of the debug serial port
// Assumes: one packed struct of state per module
// Notes: none
package debug_uart_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic rd_fresh;
        logic [15:0] div;
        logic [7:0] rx_byte;
        logic rx_full;
        logic overrun;
        logic [7:0] tx_byte;
        logic tx_full;
        logic load;
        logic tx_irq;
        logic rx_irq;
        rx_state_t rx_state;
        logic [7:0] rx_cnt;
        logic [2:0] rx_bits;
        logic [7:0] rx_shift;
        logic rx_prev;
    } core_state_t;

    typedef struct packed {
        logic [9:0] frame;
        logic [3:0] bits;
        logic [7:0] cnt;
        logic shifting;
        logic line;
    } tx_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } pre_state_t;

endpackage : debug_uart_pkg

// File: pkg/serial_link_if.sv
// Purpose: signals between the serial core, its prescaler and its transmit shifter
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface serial_link_if;
    logic [7:0] prescale;
    logic [7:0] bit_div;
    logic sample_tick;
    logic load;
    logic [7:0] load_byte;
    logic shifting;
    logic line;

    modport gen (input prescale, output sample_tick);
    modport tx (input sample_tick, bit_div, load, load_byte, output shifting, line);
    modport core (input sample_tick, shifting, line,
                  output prescale, bit_div, load, load_byte);
endinterface : serial_link_if

// File: hw/baud_prescaler.sv
// Purpose: first divider stage, one sample tick every prescale+1 clocks
// Assumes: prescale may change at any time
// Notes: tick is registered
`timescale 1ns/1ps
module baud_prescaler (
    input wire logic clock,
    input wire logic sys_rst,
    serial_link_if.gen link
);
    debug_uart_pkg::pre_state_t p_q;
    debug_uart_pkg::pre_state_t p_d;

    always_comb begin
        p_d.cnt = p_q.cnt + 8'h01;
        p_d.tick = 1'b0;
        if (p_q.cnt >= link.prescale) begin
            p_d.cnt = 8'h00;
            p_d.tick = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            p_q <= '0;
        end else begin
            p_q <= p_d;
        end
    end

    assign link.sample_tick = p_q.tick;
endmodule : baud_prescaler

// File: hw/tx_shifter.sv
// Purpose: transmit shift register, ten bit times per frame
// Assumes: load only while not shifting
// Notes: bit time is bit_div sample ticks
`timescale 1ns/1ps
module tx_shifter (
    input wire logic clock,
    input wire logic sys_rst,
    serial_link_if.tx link
);
    debug_uart_pkg::tx_state_t t_q;
    debug_uart_pkg::tx_state_t t_d;
    logic [8:0] inc;

    always_comb begin
        t_d = t_q;
        inc = {1'b0, t_q.cnt} + 9'h001;
        if (link.load) begin
            t_d.frame = {1'b1, link.load_byte, 1'b0};
            t_d.line = 1'b0;
            t_d.shifting = 1'b1;
            t_d.cnt = 8'h00;
            t_d.bits = 4'h0;
        end else if (t_q.shifting && link.sample_tick) begin
            if (inc >= {1'b0, link.bit_div}) begin
                t_d.cnt = 8'h00;
                t_d.frame = {1'b1, t_q.frame[9:1]};
                t_d.line = t_q.frame[1];
                if (t_q.bits == `FRAME_LAST) begin
                    t_d.shifting = 1'b0;
                    t_d.line = 1'b1;
                end else begin
                    t_d.bits = t_q.bits + 4'h1;
                end
            end else begin
                t_d.cnt = inc[7:0];
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            t_q <= '0;
            t_q.line <= 1'b1;
        end else begin
            t_q <= t_d;
        end
    end

    assign link.shifting = t_q.shifting;
    assign link.line = t_q.line;
endmodule : tx_shifter

// File: tb/serial_terminal_model.sv
// Purpose: far-side serial terminal, sends and records framed bytes
// Assumes: bit time is BIT_CLKS clocks, same clock as the port
// Notes: stop level is chosen per byte so a bad frame can be sent on purpose
`timescale 1ns/1ps
module serial_terminal_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clock,
    input wire logic serial_tx,
    output logic serial_rx
);
    // ----------------------------------------
    // received frames, stop level in bit 8
    // ----------------------------------------
    logic [8:0] got[$];
    logic [8:0] frame_in;
    int i;

    initial serial_rx = 1'b1;

    task send_byte(input logic [7:0] b, input logic stop_level);
        logic [9:0] frame;
        int k;
        frame = {stop_level, b, 1'b0};
        @(posedge clock);
        for (k = 0; k < 10; k++) begin
            serial_rx <= frame[k];
            repeat (BIT_CLKS) @(posedge clock);
        end
        serial_rx <= 1'b1;
    endtask : send_byte

    // low pulse shorter than half a bit, must not open a frame
    task glitch(input int n);
        @(posedge clock);
        serial_rx <= 1'b0;
        repeat (n) @(posedge clock);
        serial_rx <= 1'b1;
    endtask : glitch

    // sample mid bit, so a prescaler phase slip of a clock or two is harmless
    initial forever begin
        @(negedge serial_tx);
        repeat (BIT_CLKS / 2) @(posedge clock);
        for (i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge clock);
            frame_in[i] = serial_tx;
        end
        got.push_back(frame_in);
    end
endmodule : serial_terminal_model

// File: tb/debug_serial_uart_bench.sv
// Purpose: register-level tests of the debug serial port
// Assumes: divider 0x0108, so one bit is 16 clocks
// Notes: partner model stands on the serial lines
`timescale 1ns/1ps
module debug_serial_uart_bench;
    localparam int BIT_CLKS = 16;
    localparam int CEILING = 12000;
    localparam logic [17:0] ST = 18'h300A0;
    localparam logic [17:0] LOW = 18'h300A4;
    localparam logic [17:0] HIGH = 18'h300A8;
    localparam logic [17:0] DIV = 18'h300AC;

    logic clock, sys_rst, read, write, waitrequest, serial_rx, serial_tx;
    logic tx_irq, rx_irq, tx_prev, rx_prev;
    logic [17:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata;
    int mismatches, total_checks, cycles, tx_count, rx_count;

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    debug_serial_uart dut_u (.clock(clock), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .serial_rx(serial_rx),
        .serial_tx(serial_tx), .tx_irq(tx_irq), .rx_irq(rx_irq));

    serial_terminal_model #(.BIT_CLKS(BIT_CLKS)) partner_u (.clock(clock),
        .serial_tx(serial_tx), .serial_rx(serial_rx));

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ----------------------------------------
    // bus master, held until waitrequest seen low
    // ----------------------------------------
    task bus_access(input logic wr, input logic [17:0] a, input logic [31:0] d,
                    input logic [3:0] be, output logic [31:0] q);
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        // no fixed count: only the bench timeout ends a hung access
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_access

    task wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus_access(1'b1, a, d, be, q);
    endtask : wr

    task rd_chk(input string what, input logic [17:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_access(1'b0, a, 32'h0000_0000, 4'hF, q);
        check(what, q, exp);
    endtask : rd_chk

    task wait_tx(input int n);
        while (tx_count < n) @(posedge clock);
    endtask : wait_tx

    task wait_rx(input int n);
        while (rx_count < n) @(posedge clock);
    endtask : wait_rx

    task wait_sent(input int n);
        while (partner_u.got.size() < n) @(posedge clock);
    endtask : wait_sent

    // ----------------------------------------
    // irq monitor and timeout
    // ----------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (tx_irq === 1'b1) tx_count++;
        if (rx_irq === 1'b1) rx_count++;
        if (tx_irq === 1'b1 && tx_prev === 1'b1) check("tx_irq width", 32'h2, 32'h1);
        if (rx_irq === 1'b1 && rx_prev === 1'b1) check("rx_irq width", 32'h2, 32'h1);
        tx_prev = tx_irq;
        rx_prev = rx_irq;
        if (cycles == CEILING) begin
            mismatches++;
            final_report;
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 18'h00000;
        byteenable = 4'h0;
        writedata = 32'h0000_0000;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        check("idle line", {31'h0, serial_tx}, 32'h1);
        rd_chk("status reset", ST, 32'h0);
        rd_chk("divider reset", DIV, 32'h0);
        rd_chk("byte low reset", LOW, 32'h0);
        rd_chk("unmapped", 18'h300B0, 32'h0);
        wr(DIV, 32'hFFFF_0108, 4'h3);
        rd_chk("divider", DIV, 32'h0000_0108);
        wr(ST, 32'h0000_000F, 4'hF);
        rd_chk("status read only", ST, 32'h0);
        $display("test registers done");
        wr(LOW, 32'hFFFF_FFA5, 4'hF);
        wr(HIGH, 32'h0000_3C00, 4'h2);
        rd_chk("status tx full", ST, 32'h3);
        check("tx irq count", tx_count, 32'h1);
        wait_tx(2);
        rd_chk("status tx reload", ST, 32'h1);
        wait_sent(2);
        check("first frame", {23'h0, partner_u.got[0]}, 32'h1A5);
        check("second frame", {23'h0, partner_u.got[1]}, 32'h13C);
        repeat (2 * BIT_CLKS) @(posedge clock);
        rd_chk("status tx idle", ST, 32'h0);
        check("line after frames", {31'h0, serial_tx}, 32'h1);
        $display("test transmit done");
        partner_u.send_byte(8'h5A, 1'b1);
        wait_rx(1);
        rd_chk("status rx full", ST, 32'h4);
        partner_u.send_byte(8'hC3, 1'b1);
        wait_rx(2);
        rd_chk("status overrun", ST, 32'hC);
        rd_chk("byte low data", LOW, 32'h0000_00C3);
        rd_chk("status after read", ST, 32'h8);
        partner_u.send_byte(8'h81, 1'b1);
        wait_rx(3);
        rd_chk("status no overrun", ST, 32'h4);
        rd_chk("byte high data", HIGH, 32'h0000_8100);
        $display("test receive done");
        partner_u.send_byte(8'h77, 1'b0);
        repeat (2 * BIT_CLKS) @(posedge clock);
        check("rx irq count", rx_count, 32'h3);
        rd_chk("status bad stop", ST, 32'h0);
        rd_chk("byte kept", LOW, 32'h0000_0081);
        $display("test bad stop done");
        partner_u.glitch(BIT_CLKS / 4);
        wr(LOW, 32'h0000_0011, 4'h2);
        repeat (10 * BIT_CLKS) @(posedge clock);
        check("rx irq after glitch", rx_count, 32'h3);
        rd_chk("status lane refused", ST, 32'h0);
        check("tx irq total", tx_count, 32'h2);
        $display("test refusals done");
        final_report;
    end
endmodule : debug_serial_uart_bench
